// *** hdl/cis_defs.vh ***
// Constants for the processor interrupt selector: offsets, fields, reset codes
`ifndef CIS_DEFS_VH
`define CIS_DEFS_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define CIS_ADDR_SEL_HIGH 32'h019C_0000
`define CIS_ADDR_SEL_LOW 32'h019C_0004

// ****************************************************************
// Field layout
// ****************************************************************
`define CIS_CODE_W 5
`define CIS_FIELD0_LSB 0
`define CIS_FIELD1_LSB 5
`define CIS_FIELD2_LSB 10
`define CIS_FIELD3_LSB 16
`define CIS_FIELD4_LSB 21
`define CIS_FIELD5_LSB 26
// Writable bits of each selector register (bits 15 and 31 outside fields)
`define CIS_SEL_MASK 32'h7FFF_7FFF

// ****************************************************************
// Reset values
// ****************************************************************
// Low: lines 4..9 codes 00100 00101 00110 00111 01000 01001
`define CIS_RST_LOW 32'h2507_18A4
// High: lines 10..15 codes 00011 01010 01011 00000 00001 00010
`define CIS_RST_HIGH 32'h0820_2D43

// ****************************************************************
// Source codes
// ****************************************************************
`define CIS_SRC_HOST 5'h00
`define CIS_SRC_TIMER0 5'h01
`define CIS_SRC_TIMER1 5'h02
`define CIS_SRC_MEMA 5'h03
`define CIS_SRC_GPIO4 5'h04
`define CIS_SRC_GPIO5 5'h05
`define CIS_SRC_GPIO6 5'h06
`define CIS_SRC_GPIO7 5'h07
`define CIS_SRC_DMA 5'h08
`define CIS_SRC_EMUDMA 5'h09
`define CIS_SRC_EXRX 5'h0A
`define CIS_SRC_EXTX 5'h0B
`define CIS_SRC_SER0TX 5'h0C
`define CIS_SRC_SER0RX 5'h0D
`define CIS_SRC_SER1TX 5'h0E
`define CIS_SRC_SER1RX 5'h0F
`define CIS_SRC_GPIO0 5'h10
`define CIS_SRC_SER2TX 5'h11
`define CIS_SRC_SER2RX 5'h12
`define CIS_SRC_TIMER2 5'h13
`define CIS_SRC_MEMB 5'h14
`define CIS_SRC_ATM 5'h17
`define CIS_SRC_VITERBI 5'h1E
`define CIS_SRC_TURBO 5'h1F

// ****************************************************************
// Line counts
// ****************************************************************
`define CIS_NUM_LINES 16
`define CIS_NUM_PROG 12
`define CIS_FIRST_PROG 4

`endif

// *** hdl/cis_source_mux.v ***
// Source multiplexer: picks one of 32 event lines by a 5-bit code
`timescale 1ns/10ps
`include "cis_defs.vh"

module cis_source_mux (
    // Event vector indexed by selector code
    input wire [31:0] eventVec,
    // Selector code
    input wire [4:0] selCode,
    // Selected event
    output wire selEvent
);

    // Reserved codes see tied-low vector bits
    assign selEvent = eventVec[selCode];

endmodule

// *** hdl/cis_apb_slave.v ***
// APB slave front end: decodes the two selector registers
`timescale 1ns/10ps
`include "cis_defs.vh"

module cis_apb_slave (
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    // Register contents for readback
    input wire [31:0] selLow,
    input wire [31:0] selHigh,
    // Decoded write strobes, combinational, high through the whole access phase
    output wire wrLow,
    output wire wrHigh,
    // Combinational read data and error
    output reg [31:0] rdData,
    output wire addrErr
);

    wire access;
    wire hitLow;
    wire hitHigh;

    assign access = psel & penable;
    assign hitLow = (paddr == `CIS_ADDR_SEL_LOW);
    assign hitHigh = (paddr == `CIS_ADDR_SEL_HIGH);
    assign wrLow = access & pwrite & hitLow;
    assign wrHigh = access & pwrite & hitHigh;
    assign addrErr = ~(hitLow | hitHigh);

    // Read mux, unmapped reads as zero
    always @* begin
        if (hitLow) begin
            rdData = selLow;
        end else if (hitHigh) begin
            rdData = selHigh;
        end else begin
            rdData = 32'h0000_0000;
        end
    end

endmodule

// *** hdl/cis_selector.v ***
// Processor interrupt selector: routes peripheral events onto 16 lines
// How it works
// - Lines 0-3 fixed: reset, non-maskable, two reserved lines held low.
// - Lines 4-15 each pick a source by a 5-bit code field.
// - All selector fields load default codes at reset.
// - Line 4 uses low bits 4:0, default 00100, GPIO/pin event 4.
// - Line 5 uses low bits 9:5, default 00101, GPIO/pin event 5.
// - Line 6 uses low bits 14:10, default 00110, GPIO/pin event 6.
// - Line 7 uses low bits 20:16, default 00111; bit 15 unused.
// - Line 8 low 25:21 default DMA; line 9 low 30:26 emulation DMA.
// - Line 10 uses high bits 4:0, default 00011, memory port A refresh.
// - Lines 11/12 high 9:5 and 14:10, exchange receive/transmit defaults.
// - Lines 13/14/15 default host port, timer zero, timer one.
// - Non-default codes select serial ports, GPIO 0, timer 2, port B.
// - Sixteen lines, line 0 highest priority, line 15 lowest.
// - High register at 0x019C0000, low register at 0x019C0004.
`timescale 1ns/10ps
`include "cis_defs.vh"

module cis_selector #(
    parameter NUM_LINES = `CIS_NUM_LINES,
    parameter NUM_PROG = `CIS_NUM_PROG
) (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Fixed sources
    input wire resetEvent,
    input wire nmiEvent,
    // Peripheral event sources
    input wire hostPortEvent,
    input wire timerZeroEvent,
    input wire timerOneEvent,
    input wire timerTwoEvent,
    input wire memPortARefreshEvent,
    input wire memPortBRefreshEvent,
    input wire gpioOrPinEvent4,
    input wire gpioOrPinEvent5,
    input wire gpioOrPinEvent6,
    input wire gpioOrPinEvent7,
    input wire gpioEventZero,
    input wire dmaCompletionEvent,
    input wire emulationDmaEvent,
    input wire emulationExchangeRxEvent,
    input wire emulationExchangeTxEvent,
    input wire serial0TxEvent,
    input wire serial0RxEvent,
    input wire serial1TxEvent,
    input wire serial1RxEvent,
    input wire serial2TxEvent,
    input wire serial2RxEvent,
    input wire atmCellPortEvent,
    input wire viterbiCoprocEvent,
    input wire turboCoprocEvent,
    // Variant presence straps, steady during operation
    input wire atmPresent,
    input wire viterbiPresent,
    input wire turboPresent,
    // Interrupt lines to the processor, bit 0 highest priority
    output reg [NUM_LINES-1:0] cpuIntLines
);

    // ************************************************************
    // Registers
    // ************************************************************
    reg [31:0] selLow_ff;
    reg [31:0] selHigh_ff;
    reg [31:0] nxt_selLow;
    reg [31:0] nxt_selHigh;
    reg [31:0] eventVec;
    wire [31:0] byteMask;
    wire wrLow;
    wire wrHigh;
    wire addrErr;
    wire [31:0] rdData;
    wire [NUM_PROG-1:0] progEvent;
    wire [5*NUM_PROG-1:0] codeBus;

    // ************************************************************
    // Bus front end
    // ************************************************************

    // Address decode and read mux
    cis_apb_slave u_apb (
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .selLow(selLow_ff),
        .selHigh(selHigh_ff),
        .wrLow(wrLow),
        .wrHigh(wrHigh),
        .rdData(rdData),
        .addrErr(addrErr)
    );

    // Byte lanes from strobes; a read ignores them
    assign byteMask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    // Bus response: one wait state, answer registered on the access cycle
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            if (psel & penable & ~pready) begin
                pready <= 1'b1;
                pslverr <= addrErr;
                prdata <= pwrite ? 32'h0000_0000 : rdData;
            end else begin
                pready <= 1'b0;
                pslverr <= 1'b0;
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ************************************************************
    // Selector registers
    // ************************************************************

    // Masked byte-lane write, taken at the completing edge
    // register addressing
    always @* begin
        nxt_selLow = selLow_ff;
        nxt_selHigh = selHigh_ff;
        if (wrLow & pready) begin
            nxt_selLow = ((selLow_ff & ~byteMask) | (pwdata & byteMask)) & `CIS_SEL_MASK;
        end
        if (wrHigh & pready) begin
            nxt_selHigh = ((selHigh_ff & ~byteMask) | (pwdata & byteMask)) & `CIS_SEL_MASK;
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            selLow_ff <= `CIS_RST_LOW;
            selHigh_ff <= `CIS_RST_HIGH;
        end else begin
            selLow_ff <= nxt_selLow;
            selHigh_ff <= nxt_selHigh;
        end
    end

    // ************************************************************
    // Field extraction
    // ************************************************************

    assign codeBus[4:0] = selLow_ff[`CIS_FIELD0_LSB +: `CIS_CODE_W];
    assign codeBus[9:5] = selLow_ff[`CIS_FIELD1_LSB +: `CIS_CODE_W];
    assign codeBus[14:10] = selLow_ff[`CIS_FIELD2_LSB +: `CIS_CODE_W];
    // line 7 field, skips bit 15
    assign codeBus[19:15] = selLow_ff[`CIS_FIELD3_LSB +: `CIS_CODE_W];
    assign codeBus[24:20] = selLow_ff[`CIS_FIELD4_LSB +: `CIS_CODE_W];
    assign codeBus[29:25] = selLow_ff[`CIS_FIELD5_LSB +: `CIS_CODE_W];
    assign codeBus[34:30] = selHigh_ff[`CIS_FIELD0_LSB +: `CIS_CODE_W];
    assign codeBus[39:35] = selHigh_ff[`CIS_FIELD1_LSB +: `CIS_CODE_W];
    assign codeBus[44:40] = selHigh_ff[`CIS_FIELD2_LSB +: `CIS_CODE_W];
    assign codeBus[49:45] = selHigh_ff[`CIS_FIELD3_LSB +: `CIS_CODE_W];
    assign codeBus[54:50] = selHigh_ff[`CIS_FIELD4_LSB +: `CIS_CODE_W];
    assign codeBus[59:55] = selHigh_ff[`CIS_FIELD5_LSB +: `CIS_CODE_W];

    // ************************************************************
    // Event vector by code
    // ************************************************************

    // Each source placed at its code; reserved codes held low
    // reserved codes low
    always @* begin
        eventVec = 32'h0000_0000;
        eventVec[`CIS_SRC_HOST] = hostPortEvent;
        eventVec[`CIS_SRC_TIMER0] = timerZeroEvent;
        eventVec[`CIS_SRC_TIMER1] = timerOneEvent;
        eventVec[`CIS_SRC_MEMA] = memPortARefreshEvent;
        eventVec[`CIS_SRC_GPIO4] = gpioOrPinEvent4;
        eventVec[`CIS_SRC_GPIO5] = gpioOrPinEvent5;
        eventVec[`CIS_SRC_GPIO6] = gpioOrPinEvent6;
        eventVec[`CIS_SRC_GPIO7] = gpioOrPinEvent7;
        eventVec[`CIS_SRC_DMA] = dmaCompletionEvent;
        eventVec[`CIS_SRC_EMUDMA] = emulationDmaEvent;
        eventVec[`CIS_SRC_EXRX] = emulationExchangeRxEvent;
        eventVec[`CIS_SRC_EXTX] = emulationExchangeTxEvent;
        eventVec[`CIS_SRC_SER0TX] = serial0TxEvent;
        eventVec[`CIS_SRC_SER0RX] = serial0RxEvent;
        eventVec[`CIS_SRC_SER1TX] = serial1TxEvent;
        eventVec[`CIS_SRC_SER1RX] = serial1RxEvent;
        eventVec[`CIS_SRC_GPIO0] = gpioEventZero;
        eventVec[`CIS_SRC_SER2TX] = serial2TxEvent;
        eventVec[`CIS_SRC_SER2RX] = serial2RxEvent;
        eventVec[`CIS_SRC_TIMER2] = timerTwoEvent;
        eventVec[`CIS_SRC_MEMB] = memPortBRefreshEvent;
        eventVec[`CIS_SRC_ATM] = atmCellPortEvent & atmPresent;
        eventVec[`CIS_SRC_VITERBI] = viterbiCoprocEvent & viterbiPresent;
        eventVec[`CIS_SRC_TURBO] = turboCoprocEvent & turboPresent;
    end

    // ************************************************************
    // Per-line routing
    // ************************************************************

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PROG; gi = gi + 1) begin : g_line
            cis_source_mux u_mux (
                .eventVec(eventVec),
                .selCode(codeBus[5*gi +: 5]),
                .selEvent(progEvent[gi])
            );
        end
    endgenerate

    // Output register, line 0 highest priority at bit 0
    // fixed lines, follows current field
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            cpuIntLines <= {NUM_LINES{1'b0}};
        end else begin
            cpuIntLines <= {progEvent, 2'b00, nmiEvent, resetEvent};
        end
    end

endmodule

// *** verif/cis_event_src.sv ***
// Peripheral event source bank, one line per selector code
`timescale 1ns/10ps

module cis_event_src (
    // Clock
    input wire mclk,
    // Request from the bench
    input wire [4:0] evCode,
    input wire evFire,
    // One event line per selector code
    output reg [31:0] evVec_ff
);
    // One-cycle pulse on the requested code; idle sources stay low
    always @(posedge mclk) begin
        evVec_ff <= evFire ? (32'h0000_0001 << evCode) : 32'h0000_0000;
    end
endmodule

// *** verif/cis_selector_properties.sv ***
// Port-level checks of the interrupt selector
`timescale 1ns/10ps
`include "cis_defs.vh"

module cis_selector_checker #(
    parameter NUM_LINES = 16
) (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Events and lines
    input wire resetEvent,
    input wire nmiEvent,
    input wire hostPortEvent,
    input wire timerZeroEvent,
    input wire timerOneEvent,
    input wire [NUM_LINES-1:0] cpuIntLines
);
    // Set once software has rewritten the high register
    reg hiWritten_ff;
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            hiWritten_ff <= 1'b0;
        end else if (pready && pwrite && !pslverr && paddr == `CIS_ADDR_SEL_HIGH) begin
            hiWritten_ff <= 1'b1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    AST_FIXED: assert property (!$past(rst) |-> cpuIntLines[1:0] == $past({nmiEvent, resetEvent}))
        else $error("fixed lines wrong");
    AST_RSVD: assert property (cpuIntLines[3:2] == 2'b00)
        else $error("reserved lines active");
    AST_DFLT: assert property (!$past(rst) && !hiWritten_ff |->
        cpuIntLines[15:13] == $past({timerOneEvent, timerZeroEvent, hostPortEvent}))
        else $error("default routing wrong");
    AST_WAIT: assert property (psel && penable && !pready |=> pready)
        else $error("no answer after one wait");
    AST_PULSE: assert property (pready |=> !pready)
        else $error("ready held too long");
    AST_CAUSE: assert property (pready |-> psel && penable && $past(psel && penable))
        else $error("ready without access");
    AST_ERR: assert property (pready |-> pslverr == (paddr != `CIS_ADDR_SEL_HIGH && paddr != `CIS_ADDR_SEL_LOW))
        else $error("error flag wrong");
    AST_GAP: assert property (pready && !pwrite |-> !prdata[15] && !prdata[31])
        else $error("unused bit read back");

    // Main scenarios
    cover property (pready && pslverr);
    cover property (pready && !pwrite && !pslverr);
    cover property ($rose(cpuIntLines[15]));
endmodule

bind cis_selector cis_selector_checker #(.NUM_LINES(NUM_LINES)) chk (
    .mclk, .rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .resetEvent, .nmiEvent, .hostPortEvent, .timerZeroEvent, .timerOneEvent, .cpuIntLines
);

// *** verif/tb_cpu_interrupt_selector.sv ***
// Self-checking bench for the interrupt selector
`timescale 1ns/10ps
`include "cis_defs.vh"

`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin num_errors++; $display("BAD %s exp %h got %h", n, e, s); end end

module tb_cpu_interrupt_selector;
    logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, rd;
    logic [3:0] pstrb = 4'hF;
    logic resetEvent = 1'b0, nmiEvent = 1'b0, evFire = 1'b0, er;
    logic [2:0] present = 3'b111;
    logic [4:0] evCode = 5'h00;
    logic [15:0] ln;
    wire [31:0] prdata, ev;
    wire pready, pslverr;
    wire [15:0] cpuIntLines;
    int num_errors = 0, compares = 0, cyc = 0;
    // Default codes of lines 4 to 15
    logic [4:0] dflt [12] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
                              5'h03, 5'h0A, 5'h0B, 5'h00, 5'h01, 5'h02};
    localparam logic [31:0] RST_LOW = {1'b0, 5'h09, 5'h08, 5'h07, 1'b0, 5'h06, 5'h05, 5'h04};

    // Clock
    initial begin
        forever #25 mclk = ~mclk;
    end

    cis_event_src src (.mclk, .evCode, .evFire, .evVec_ff(ev));

    cis_selector dut (
        .mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .resetEvent, .nmiEvent, .hostPortEvent(ev[0]), .timerZeroEvent(ev[1]),
        .timerOneEvent(ev[2]), .memPortARefreshEvent(ev[3]), .gpioOrPinEvent4(ev[4]),
        .gpioOrPinEvent5(ev[5]), .gpioOrPinEvent6(ev[6]), .gpioOrPinEvent7(ev[7]),
        .dmaCompletionEvent(ev[8]), .emulationDmaEvent(ev[9]),
        .emulationExchangeRxEvent(ev[10]), .emulationExchangeTxEvent(ev[11]),
        .serial0TxEvent(ev[12]), .serial0RxEvent(ev[13]), .serial1TxEvent(ev[14]),
        .serial1RxEvent(ev[15]), .gpioEventZero(ev[16]), .serial2TxEvent(ev[17]),
        .serial2RxEvent(ev[18]), .timerTwoEvent(ev[19]), .memPortBRefreshEvent(ev[20]),
        .atmCellPortEvent(ev[23]), .viterbiCoprocEvent(ev[30]), .turboCoprocEvent(ev[31]),
        .atmPresent(present[0]), .viterbiPresent(present[1]), .turboPresent(present[2]),
        .cpuIntLines
    );

    // One APB transfer; request held until ready is sampled high
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Pulse one source and capture the lines when it arrives
    task fire(input logic [4:0] c);
        @(posedge mclk);
        evCode <= c;
        evFire <= 1'b1;
        @(posedge mclk);
        evFire <= 1'b0;
        @(posedge mclk);
        #1 ln = cpuIntLines;
    endtask

    task t_reset_regs;
        apb(1'b0, `CIS_ADDR_SEL_LOW, 32'h0000_0000, 4'hF);
        `CHK("low reset", RST_LOW, rd)
        apb(1'b0, `CIS_ADDR_SEL_HIGH, 32'h0000_0000, 4'hF);
        `CHK("high reset", {1'b0, 15'h0820, 1'b0, 15'h2D43}, rd)
    endtask

    task t_defaults;
        for (int k = 0; k < 12; k++) begin
            fire(dflt[k]);
            `CHK("default line", 16'h0010 << k, ln)
        end
    endtask

    task t_fixed;
        for (int i = 3; i >= 0; i--) begin
            @(posedge mclk);
            {nmiEvent, resetEvent} <= i[1:0];
            repeat (2) @(posedge mclk);
            #1 `CHK("fixed lines", {2'b00, i[1:0]}, cpuIntLines[3:0])
        end
    endtask

    // Every code on line 9, units present then absent
    task t_codes;
        logic [15:0] x;
        for (int p = 1; p >= 0; p--) begin
            @(posedge mclk);
            present <= {3{p[0]}};
            for (int c = 0; c < 32; c++) begin
                apb(1'b1, `CIS_ADDR_SEL_LOW, {1'b0, c[4:0], RST_LOW[25:0]}, 4'hF);
                fire(c[4:0]);
                x = 16'h0000;
                for (int k = 0; k < 12; k++) if (dflt[k] == c[4:0] && k != 5) x[k + 4] = 1'b1;
                if (!(c inside {21, 22, [24:29]}) && (p == 1 || !(c inside {23, 30, 31})))
                    x[9] = 1'b1;
                `CHK("code on line 9", x, ln)
            end
        end
        apb(1'b1, `CIS_ADDR_SEL_LOW, RST_LOW, 4'hF);
    endtask

    task t_bus;
        apb(1'b1, `CIS_ADDR_SEL_HIGH, 32'hFFFF_FFFF, 4'hF);
        `CHK("write err", 1'b0, er)
        apb(1'b0, `CIS_ADDR_SEL_HIGH, 32'h0000_0000, 4'hF);
        `CHK("masked bits", 32'h7FFF_7FFF, rd)
        apb(1'b1, `CIS_ADDR_SEL_LOW, 32'h0000_0000, 4'h1);
        apb(1'b0, `CIS_ADDR_SEL_LOW, 32'h0000_0000, 4'hF);
        `CHK("lane write", {RST_LOW[31:8], 8'h00}, rd)
        apb(1'b1, 32'h019C_0008, 32'h0000_0000, 4'hF);
        `CHK("unmapped write", 1'b1, er)
        apb(1'b0, 32'h019C_0008, 32'h0000_0000, 4'hF);
        `CHK("unmapped read", 33'h1_0000_0000, {er, rd})
    endtask

    task stop_test;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            stop_test;
        end
    end

    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        t_reset_regs;
        t_defaults;
        t_fixed;
        t_codes;
        t_bus;
        stop_test;
    end
endmodule
